// ===== rtl/drb_defs.svh
// Constants for the burst access and refresh block of the DRAM device
`ifndef DRB_DEFS_SVH
`define DRB_DEFS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DRB_CLK_MHZ       100
`define DRB_TRFC_NS       105
`define DRB_TRFC_CYCLES   ((`DRB_TRFC_NS * `DRB_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define DRB_COL_BITS      9
`define DRB_ROW_BITS      13
`define DRB_BANK_BITS     2
`define DRB_DQ_BITS       16
`define DRB_QDEPTH        12

// ----------------------------------------------------------------
// Mode field encodings and limits
// ----------------------------------------------------------------
`define DRB_BL_CODE_4     3'h2
`define DRB_BL_CODE_8     3'h3
`define DRB_AL_MAX        3'h6
`define DRB_RD_TAP_OFS    4'h3
`define DRB_WR_TAP_OFS    4'h2
`define DRB_ALL_BANKS_BIT 10

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DRB_ROW_RESET     13'h0000
`define DRB_PIN_IDLE      20'hF0000

`endif

// ===== rtl/drb_pkg.sv
// Types shared by the burst access and refresh block
package drb_pkg;
  `include "drb_defs.svh"

  // ----------------------------------------------------------------
  // Decoded command
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_DESEL = 3'b000,
    CMD_NOP   = 3'b001,
    CMD_ACT   = 3'b010,
    CMD_RD    = 3'b011,
    CMD_WR    = 3'b100,
    CMD_PRE   = 3'b101,
    CMD_REF   = 3'b110,
    CMD_OTHER = 3'b111
  } drb_cmd_t;

  // Posted column command waiting out its latency
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [1:0] ba;
    logic [8:0] col;
  } drb_colcmd_t;

  // Whole state of the top module
  typedef struct packed {
    logic [19:0]                   pin_s1;     // cs,ras,cas,we,cke,ba,addr
    logic [19:0]                   pin_s2;
    logic [31:0]                   dq_s1;      // fall,rise write data
    logic [31:0]                   dq_s2;
    drb_colcmd_t [`DRB_QDEPTH-1:0] queue;
    logic                          bst_active;
    logic                          bst_wr;
    logic                          bst_bl8;
    logic                          bst_il;
    logic [1:0]                    bst_ba;
    logic [8:0]                    bst_col;
    logic [1:0]                    bst_beat;
    logic                          rd_v1;
    logic [12:0]                   ref_row;
    logic [7:0]                    rfc_cnt;
    logic                          ref_busy;
    logic [3:0]                    bank_open;
    logic [31:0]                   dq_out;
    logic                          dq_oe;
    logic                          dqs;
    logic                          dqs_oe;
    logic                          cfg_err;
  } drb_state_t;
endpackage : drb_pkg

// ===== rtl/drb_col_mem.sv
// Column storage with two write and two registered read ports
`timescale 1ns/1ns
module drb_col_mem #(
  parameter int DW = 16,
  parameter int AW = 11
) (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // Write side
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_wa0,
  input  wire logic [AW-1:0] i_wa1,
  input  wire logic [DW-1:0] i_wd0,
  input  wire logic [DW-1:0] i_wd1,
  // Read side
  input  wire logic [AW-1:0] i_ra0,
  input  wire logic [AW-1:0] i_ra1,
  output logic      [DW-1:0] o_rd0,
  output logic      [DW-1:0] o_rd1
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DW-1:0] mem [0:(1<<AW)-1];  // One word per bank and column

  // Two beats are written per clock
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem[i_wa0] <= i_wd0;
      mem[i_wa1] <= i_wd1;
    end
  end

  // Read data leave through a register
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rd0 <= '0;
      o_rd1 <= '0;
    end
    else
    begin
      o_rd0 <= mem[i_ra0];
      o_rd1 <= mem[i_ra1];
    end
  end
endmodule : drb_col_mem

// ===== rtl/drb_burst_access.sv
// Command decode, refresh, posted column commands and bursts of the DRAM
`timescale 1ns/1ns
// Functional notes
// R01: Host issues each refresh separately.
// R02: Refresh row from internal counter; address ignored.
// R03: Host keeps average refresh spacing within tREFI.
// R04: Refresh completion leaves all banks idle.
// R05: Host waits tRFC after refresh.
// R06: Host posts at most eight refreshes.
// R07: NOP changes no state, like deselect.
// R08: Chip select high disables command decoding.
// R09: Burst stays inside its aligned column group.
// R10: Host interrupts only same-direction BL8 bursts.
// R11: Host spaces column commands by tCCD.
// R12: Column command held additive latency, then executed.
// R13: Host sets nonzero additive latency before early commands.
// R14: Read latency AL plus CL; write one less.
// R15: Burst length four or eight; type selectable.
// R16: Burst column order sequential or interleaved.
// R17: No burst stop; bursts end or restart.
// R18: Read data start read latency after command.
// R19: Read strobe low one clock before data.
// R20: Host drives write strobe preamble and data.
// R21: Data after a write burst ignored.
// R22: Host waits write recovery before precharge.
// R23: Additive latency zero through six supported.
// R24: Host refreshes only with all banks idle.
module drb_burst_access
  import drb_pkg::*;
#(
  parameter int TRFC_CYCLES = `DRB_TRFC_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Command and address pins
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic        i_cke,
  input  wire logic [1:0]  i_ba,
  input  wire logic [12:0] i_addr,
  // Write data pins, both edges of one clock
  input  wire logic [15:0] i_dq_rise,
  input  wire logic [15:0] i_dq_fall,
  // Mode settings
  input  wire logic [2:0]  i_cas_lat,
  input  wire logic [2:0]  i_add_lat,
  input  wire logic [2:0]  i_burst_len,
  input  wire logic        i_burst_interleave,
  // Read data and strobe pins
  output logic      [15:0] o_dq_rise,
  output logic      [15:0] o_dq_fall,
  output logic             o_dq_oe,
  output logic             o_dqs,
  output logic             o_dqs_oe,
  // Status
  output logic      [3:0]  o_bank_open,
  output logic             o_refresh_busy,
  output logic      [12:0] o_refresh_row,
  output logic             o_cfg_error
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Command from the synchronised pin group
  function automatic drb_cmd_t decode_cmd(input logic [19:0] p);
    logic [3:0] c;
    c = p[19:16];
    if (c[3])
      return CMD_DESEL;                         // R08
    unique case (c[2:0])
      3'b111:  return CMD_NOP;                  // R07
      3'b011:  return CMD_ACT;
      3'b101:  return CMD_RD;
      3'b100:  return CMD_WR;
      3'b010:  return CMD_PRE;
      3'b001:  return p[15] ? CMD_REF : CMD_OTHER;
      default: return CMD_OTHER;
    endcase
  endfunction : decode_cmd

  // Column of one beat of a burst
  function automatic logic [8:0] burst_col(input logic [8:0] start, input logic [2:0] idx,
                                           input logic il);
    logic [2:0] o;
    o = il ? (start[2:0] ^ idx)                                       // R16
           : {start[2] ^ idx[2], start[1:0] + idx[1:0]};               // R16
    return {start[8:3], o};                                           // R09
  endfunction : burst_col

  // ----------------------------------------------------------------
  // State and combinational signals
  // ----------------------------------------------------------------
  drb_state_t  st_reg;            // All registered state
  drb_state_t  st_next;           // Its next value
  drb_cmd_t    cmd;               // Command decoded this cycle
  logic [3:0]  rl;                // Read latency
  logic [3:0]  rd_tap;            // Queue slot where reads launch
  logic [3:0]  wr_tap;            // Queue slot where writes launch
  logic        bl8;               // Burst of eight selected
  drb_colcmd_t rd_ent;            // Entry at the read slot
  drb_colcmd_t wr_ent;            // Entry at the write slot
  logic        cur_v;             // A burst beat pair happens now
  logic        cur_wr;            // It writes
  logic [1:0]  cur_ba;            // Its bank
  logic [8:0]  cur_col;           // Its start column
  logic [1:0]  cur_beat;          // Its beat pair
  logic        cur_il;            // Its ordering
  logic        cur_bl8;           // Its length
  logic [10:0] ma0;               // Memory address of first beat
  logic [10:0] ma1;               // Memory address of second beat
  logic [15:0] rd0;               // Read word, first beat
  logic [15:0] rd1;               // Read word, second beat

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // Pins pass two flip-flops before use
    st_next.pin_s1 = {i_cs_n, i_ras_n, i_cas_n, i_we_n, i_cke, i_ba, i_addr};
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.dq_s1  = {i_dq_fall, i_dq_rise};
    st_next.dq_s2  = st_reg.dq_s1;
    cmd = decode_cmd(st_reg.pin_s2);

    // Latencies from mode settings
    rl     = 4'({1'b0, i_add_lat} + {1'b0, i_cas_lat});          // R14
    rd_tap = 4'(rl - `DRB_RD_TAP_OFS);                            // R18
    wr_tap = 4'(rl - `DRB_WR_TAP_OFS);                            // R14
    bl8    = (i_burst_len == `DRB_BL_CODE_8);                     // R15
    st_next.cfg_err = ((i_burst_len != `DRB_BL_CODE_4) && !bl8)   // R15
                   || (i_add_lat > `DRB_AL_MAX);                  // R23

    // Posted column commands shift toward their launch slots
    for (int i = `DRB_QDEPTH - 1; i > 0; i--)
      st_next.queue[i] = st_reg.queue[i-1];                       // R12
    st_next.queue[0].valid = (cmd == CMD_RD) || (cmd == CMD_WR);   // R12
    st_next.queue[0].wr    = (cmd == CMD_WR);
    st_next.queue[0].ba    = st_reg.pin_s2[14:13];
    st_next.queue[0].col   = st_reg.pin_s2[8:0];

    // Launch a burst, or carry on the running one
    rd_ent = st_reg.queue[rd_tap];
    wr_ent = st_reg.queue[wr_tap];
    if (rd_ent.valid && !rd_ent.wr)
    begin
      // Read launch also interrupts a running read
      cur_v = 1'b1; cur_wr = 1'b0; cur_ba = rd_ent.ba;             // R17
      cur_col = rd_ent.col; cur_beat = 2'h0;
      cur_il = i_burst_interleave; cur_bl8 = bl8;
    end
    else if (wr_ent.valid && wr_ent.wr)
    begin
      // Write launch also interrupts a running write
      cur_v = 1'b1; cur_wr = 1'b1; cur_ba = wr_ent.ba;             // R17
      cur_col = wr_ent.col; cur_beat = 2'h0;
      cur_il = i_burst_interleave; cur_bl8 = bl8;
    end
    else
    begin
      // Continue the burst in progress
      cur_v = st_reg.bst_active; cur_wr = st_reg.bst_wr; cur_ba = st_reg.bst_ba;
      cur_col = st_reg.bst_col; cur_beat = st_reg.bst_beat;
      cur_il = st_reg.bst_il; cur_bl8 = st_reg.bst_bl8;
    end
    ma0 = {cur_ba, burst_col(cur_col, {cur_beat, 1'b0}, cur_il)};   // R16
    ma1 = {cur_ba, burst_col(cur_col, {cur_beat, 1'b1}, cur_il)};   // R16
    st_next.bst_wr   = cur_wr;
    st_next.bst_ba   = cur_ba;
    st_next.bst_col  = cur_col;
    st_next.bst_il   = cur_il;
    st_next.bst_bl8  = cur_bl8;
    st_next.bst_beat = 2'(cur_beat + 2'h1);
    // Burst ends after two or four beat pairs
    st_next.bst_active = cur_v && (cur_bl8 ? (cur_beat != 2'h3)    // R21
                                           : (cur_beat != 2'h1));  // R21

    // Read output pipeline: address, memory register, pin register
    st_next.rd_v1  = cur_v && !cur_wr;
    st_next.dq_oe  = st_reg.rd_v1;                                 // R18
    st_next.dq_out = {rd1, rd0};                                   // R18
    st_next.dqs    = st_reg.rd_v1;                                 // R19
    st_next.dqs_oe = (cur_v && !cur_wr) || st_reg.rd_v1;           // R19

    // Bank tracking
    if (cmd == CMD_ACT)
      st_next.bank_open[st_reg.pin_s2[14:13]] = 1'b1;
    else if (cmd == CMD_PRE)
    begin
      if (st_reg.pin_s2[`DRB_ALL_BANKS_BIT])
        st_next.bank_open = 4'h0;
      else
        st_next.bank_open[st_reg.pin_s2[14:13]] = 1'b0;
    end

    // Auto refresh: internal row counter, busy for the cycle time
    if (cmd == CMD_REF)
    begin
      st_next.ref_row  = 13'(st_reg.ref_row + 13'h0001);           // R02
      st_next.ref_busy = 1'b1;
      st_next.rfc_cnt  = 8'(TRFC_CYCLES - 1);
    end
    else if (st_reg.ref_busy)
    begin
      if (st_reg.rfc_cnt == 8'h00)
      begin
        st_next.ref_busy  = 1'b0;
        // An activate decoded in the same cycle still opens its bank
        st_next.bank_open = (cmd == CMD_ACT) ? 4'(4'h1 << st_reg.pin_s2[14:13])
                                             : 4'h0;               // R04
      end
      else
        st_next.rfc_cnt = 8'(st_reg.rfc_cnt - 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      st_reg         <= '0;
      st_reg.pin_s1  <= `DRB_PIN_IDLE;
      st_reg.pin_s2  <= `DRB_PIN_IDLE;
      st_reg.ref_row <= `DRB_ROW_RESET;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Column storage
  // ----------------------------------------------------------------
  drb_col_mem #(
    .DW (16),
    .AW (11)
  ) u_mem (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_we    (cur_v && cur_wr),                                    // R21
    .i_wa0   (ma0),
    .i_wa1   (ma1),
    .i_wd0   (st_reg.dq_s2[15:0]),
    .i_wd1   (st_reg.dq_s2[31:16]),
    .i_ra0   (ma0),
    .i_ra1   (ma1),
    .o_rd0   (rd0),
    .o_rd1   (rd1)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_dq_rise      = st_reg.dq_out[15:0];
  assign o_dq_fall      = st_reg.dq_out[31:16];
  assign o_dq_oe        = st_reg.dq_oe;
  assign o_dqs          = st_reg.dqs;
  assign o_dqs_oe       = st_reg.dqs_oe;
  assign o_bank_open    = st_reg.bank_open;
  assign o_refresh_busy = st_reg.ref_busy;
  assign o_refresh_row  = st_reg.ref_row;
  assign o_cfg_error    = st_reg.cfg_err;
endmodule : drb_burst_access

// ===== testbench/drb_burst_access_chk.sv
// Port assertions for the burst access and refresh block
`timescale 1ns/1ns
`include "drb_defs.svh"
module drb_burst_access_chk
  import drb_pkg::*;
#(
  parameter int TRFC_CYCLES = 2
) (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // Command pins and mode
  input wire logic        i_cs_n,
  input wire logic        i_ras_n,
  input wire logic        i_cas_n,
  input wire logic        i_we_n,
  input wire logic        i_cke,
  input wire logic [2:0]  i_add_lat,
  input wire logic [2:0]  i_burst_len,
  // Outputs
  input wire logic        o_dq_oe,
  input wire logic        o_dqs,
  input wire logic        o_dqs_oe,
  input wire logic [3:0]  o_bank_open,
  input wire logic        o_refresh_busy,
  input wire logic [12:0] o_refresh_row,
  input wire logic        o_cfg_error
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Refresh seen on the pins, and an illegal mode setting
  wire ref_pin = !i_cs_n && !i_ras_n && !i_cas_n && i_we_n && i_cke;
  wire bad_cfg = (i_burst_len != `DRB_BL_CODE_4 && i_burst_len != `DRB_BL_CODE_8) || i_add_lat > `DRB_AL_MAX;

  AST_DQ_STROBE: assert property (o_dq_oe |-> o_dqs_oe && o_dqs)
    else $error("data driven without high strobe");
  AST_PREAMBLE: assert property ($rose(o_dqs_oe) |-> !o_dqs && !o_dq_oe ##1 o_dq_oe)
    else $error("strobe preamble not one clock");
  AST_MIN_BURST: assert property ($fell(o_dq_oe) |-> $past(o_dq_oe, 2))
    else $error("read burst shorter than four beats");
  AST_REF_CAUSE: assert property ($rose(o_refresh_busy) |-> $past(ref_pin, 3))
    else $error("refresh without refresh command");
  AST_REF_START: assert property (ref_pin && !o_refresh_busy |-> ##[2:4] o_refresh_busy)
    else $error("refresh command not executed");
  AST_REF_ROW: assert property ($changed(o_refresh_row) |-> $rose(o_refresh_busy) && o_refresh_row == $past(o_refresh_row) + 13'h1)
    else $error("refresh row not stepped by one");
  AST_REF_IDLE: assert property ($fell(o_refresh_busy) |-> ##[0:1] o_bank_open == 4'h0)
    else $error("banks open after refresh");
  AST_CFG_ERR: assert property (o_cfg_error == $past(bad_cfg))
    else $error("mode error flag wrong");

  cover property ($rose(o_dq_oe));
  cover property ($fell(o_refresh_busy));
  cover property ($rose(o_cfg_error));
endmodule : drb_burst_access_chk

bind drb_burst_access drb_burst_access_chk #(.TRFC_CYCLES(TRFC_CYCLES)) i_drb_burst_access_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n),
  .i_we_n(i_we_n), .i_cke(i_cke), .i_add_lat(i_add_lat), .i_burst_len(i_burst_len),
  .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .o_bank_open(o_bank_open),
  .o_refresh_busy(o_refresh_busy), .o_refresh_row(o_refresh_row), .o_cfg_error(o_cfg_error));

// ===== testbench/drb_host_model.sv
// Host controller model driving command and write data pins
`timescale 1ns/1ns
module drb_host_model (
  // Clock
  input  wire logic        i_clk,
  // Command pins
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic             o_cke,
  output logic      [1:0]  o_ba,
  output logic      [12:0] o_addr,
  // Write data pins
  output logic      [15:0] o_dq_rise,
  output logic      [15:0] o_dq_fall
);
  // Deselected at time zero
  initial
  begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke} = 5'h1F;
    {o_ba, o_addr, o_dq_rise, o_dq_fall} = 47'h0;
  end
  // One command per call, then deselect with the lines inverted
  task automatic cmd(input logic [3:0] c, input logic k, input logic [1:0] b, input logic [12:0] a);
    @(posedge i_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke} <= {c, k};
    {o_ba, o_addr} <= {b, a};
    @(posedge i_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke} <= {1'b1, ~c[2:0], 1'b1};
    {o_ba, o_addr} <= ~{b, a};
  endtask : cmd
  // Beat pairs once write latency runs out, inverted data after the burst
  task automatic wr_data(input int rl, input logic [127:0] d, input logic b8);
    // The device samples pair 0 write latency edges after it registers the command
    repeat (rl - 2) @(posedge i_clk);
    for (int k = 0; k < (b8 ? 4 : 2); k++)
    begin
      {o_dq_fall, o_dq_rise} <= d[32*k +: 32];
      @(posedge i_clk);
    end
    {o_dq_fall, o_dq_rise} <= ~d[31:0];
  endtask : wr_data
endmodule : drb_host_model

// ===== testbench/drb_burst_access_tb.sv
// Self-checking bench for the burst access and refresh block
`timescale 1ns/1ns
`include "drb_defs.svh"
module drb_burst_access_tb;
  logic        i_clk, i_reset, cs_n, ras_n, cas_n, we_n, cke, il, dq_oe, dqs, dqs_oe, busy, cerr;
  logic [1:0]  ba, b;
  logic [2:0]  cl, al, bl;
  logic [3:0]  bopen;
  logic [8:0]  s;
  logic [12:0] addr, row;
  logic [15:0] dr, df, qr, qf;
  logic [15:0] mem [4][512]; // Bench copy of the array
  logic [31:0] exp_d [int];  // Expected beat pair by cycle
  bit          exp_p [int];  // Expected preamble cycles
  int          error_cnt, n_checks, cyc, wt;

  drb_burst_access #(.TRFC_CYCLES(2)) i_drb_burst_access (
    .i_clk(i_clk), .i_reset(i_reset), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_cke(cke), .i_ba(ba), .i_addr(addr), .i_dq_rise(dr), .i_dq_fall(df), .i_cas_lat(cl),
    .i_add_lat(al), .i_burst_len(bl), .i_burst_interleave(il), .o_dq_rise(qr), .o_dq_fall(qf),
    .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe), .o_bank_open(bopen), .o_refresh_busy(busy),
    .o_refresh_row(row), .o_cfg_error(cerr));
  drb_host_model i_drb_host_model (
    .i_clk(i_clk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_cke(cke),
    .o_ba(ba), .o_addr(addr), .o_dq_rise(dr), .o_dq_fall(df));

  // Clock and cycle count
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    cyc <= cyc + 1;

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Column of beat j for a start column, burst length and order
  function automatic logic [8:0] col_of(logic [8:0] st, int j, logic b8, logic ilv);
    logic [2:0] k;
    k = j[2:0];
    if (!b8)
      return {st[8:2], ilv ? st[1:0] ^ k[1:0] : st[1:0] + k[1:0]};
    return {st[8:3], ilv ? st[2:0] ^ k : {st[2] ^ k[2], st[1:0] + k[1:0]}};
  endfunction : col_of

  task automatic cmd(logic [3:0] c, logic k, logic [1:0] bk, logic [12:0] a);
    i_drb_host_model.cmd(c, k, bk, a);
  endtask : cmd

  // Write a whole eight-beat group and note it in the copy
  task automatic wr(logic [1:0] bk, logic [8:0] st, logic [127:0] d);
    cmd(4'h4, 1'b1, bk, {4'h0, st});
    i_drb_host_model.wr_data(al + cl, d, 1'b1);
    for (int j = 0; j < 8; j++)
      mem[bk][col_of(st, j, 1'b1, il)] = d[16*j +: 16];
  endtask : wr

  // Read: schedule preamble and beat pairs by cycle
  task automatic rd(logic [1:0] bk, logic [8:0] st);
    int q;
    logic b8;
    cmd(4'h5, 1'b1, bk, {4'h0, st});
    // Burst length was set one edge before the command, so read it only now
    b8 = (bl == `DRB_BL_CODE_8);
    q = cyc + 1 + al + cl;
    if (!exp_d.exists(q))
      exp_p[q] = 1'b1;
    for (int k = 0; k < (b8 ? 4 : 2); k++)
      exp_d[q+1+k] = {mem[bk][col_of(st, 2*k+1, b8, il)], mem[bk][col_of(st, 2*k, b8, il)]};
  endtask : rd

  // Output monitor, every cycle once settled
  always @(posedge i_clk)
  begin
    #1;
    if (!i_reset)
    begin
      check("dq_oe", dq_oe, exp_d.exists(cyc));
      check("dqs_oe", dqs_oe, exp_d.exists(cyc) || exp_p.exists(cyc));
      if (dqs_oe)
        check("dqs", dqs, exp_d.exists(cyc));
      if (exp_d.exists(cyc))
        check("dq", {qf, qr}, exp_d[cyc]);
    end
  end

  // Main sequence
  initial
  begin
    i_reset = 1'b1;
    cl = 3'h3;
    al = 3'h0;
    bl = `DRB_BL_CODE_4;
    il = 1'b0;
    void'($urandom(32'h3C62));
    repeat (10) @(posedge i_clk);
    i_reset <= 1'b0;
    cmd(4'h9, 1'b1, 2'h0, 13'h1FFF);
    cmd(4'h1, 1'b0, 2'h0, 13'h1FFF);
    cmd(4'h7, 1'b1, 2'h3, 13'h1FFF);
    repeat (6) @(posedge i_clk);
    check("row", row, `DRB_ROW_RESET);
    for (int k = 1; k < 4; k++)
    begin
      cmd(4'h1, 1'b1, 2'($urandom), 13'($urandom));
      for (wt = 0; wt < 30 && (busy !== 1'b0 || wt < 4); wt++)
        @(posedge i_clk);
      check("row", row, k);
      check("banks", bopen, 0);
    end
    @(posedge i_clk);
    bl <= 3'h5;
    repeat (2) @(posedge i_clk);
    #1 check("cfg", cerr, 1);
    @(posedge i_clk);
    bl <= `DRB_BL_CODE_4;
    al <= 3'h7;
    repeat (2) @(posedge i_clk);
    #1 check("cfg", cerr, 1);
    for (int n = 0; n < 40; n++)
    begin
      @(posedge i_clk);
      al <= 3'($urandom_range(6, 0));
      cl <= 3'($urandom_range(5, 3));
      il <= 1'($urandom);
      bl <= `DRB_BL_CODE_8;
      b = 2'($urandom);
      s = 9'($urandom);
      cmd(4'h3, 1'b1, b, 13'($urandom));
      wr(b, {s[8:3], 3'h0}, {$urandom, $urandom, $urandom, $urandom});
      check("banks", bopen, 4'(4'h1 << b));
      check("cfg", cerr, 0);
      @(posedge i_clk);
      bl <= n[0] ? `DRB_BL_CODE_4 : `DRB_BL_CODE_8;
      rd(b, s);
      if (n[1] && !n[0])
        rd(b, {s[8:3], 3'(s[2:0] + 3'h4)});
      repeat (24) @(posedge i_clk);
      cmd(4'h2, 1'b1, 2'h0, 13'h0400);
    end
    final_report();
  end

  // Watchdog
  initial
  begin
    #500000;
    error_cnt++;
    final_report();
  end
endmodule : drb_burst_access_tb
